/* mmac_top.sv */
/*
  mmac_top: mode derivation, segment translation and access checks for cpu
  memory and register accesses, with an apb register file and violation irq.
  assumes the cpu drives requests on clk, one answer per request next cycle.
*/
// Summary of operation
// - mode is boot, test, contactless, system or user from status and internal bits
// - a cpu address matching a segment is translated before memory is reached; privileged misses pass unchanged
// - each access is checked before it happens and blocked when not permitted
// - up to 64 segments: r/w/x rights, first and last address, relocation offset
// - each segment also carries read and write rights for hardware registers
// - a segment granting no r/w/x is disabled and never matches
// - any number of defined segments from zero to 64 works
// - memory read, write, execute and register read, write are judged separately
// - rom and eeprom split into fixed regions, not configurable
// - registers fall into five groups; decisions depend on the group
// - every access of every mode passes the checks, no bypass
// - user code reaches hardware registers only with its segment's rights
// - denied register read returns zero, denied write has no effect
// - segmentation registers are reachable only in system mode
`timescale 1ns/1ns
module mmac_top
  import mmac_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // cpu memory port
  input  wire mmac_mreq_t  mem_req,
  output mmac_mrsp_t       mem_rsp,
  // cpu register port for registers outside this block
  input  wire mmac_sreq_t  sfr_req,
  output logic             sfr_grant,
  output logic             sfr_deny,
  // exception entry sets the system bit; system mode results only when no internal mode bits are set
  input  wire logic        trap_entry,
  // status
  output mmac_mode_t       cpu_mode,
  output logic             irq
);

  mmac_seg_t [SEG_N-1:0] tab_q;
  logic [PSW-1:0]        psh_q;
  logic [1:0]            ib_q;
  logic [SEG_IW-1:0]     sidx_q;
  logic [SEG_IW-1:0]     cur_seg_q;
  logic [VW-1:0]         vstat_q;
  logic [VW-1:0]         ven_q;
  logic [VW-1:0]         vstat_d;
  logic [31:0]           prdata_q;
  logic                  pready_q;
  logic                  pslverr_q;
  mmac_mrsp_t            mem_rsp_q;
  logic                  sfr_grant_q;
  logic                  sfr_deny_q;
  mmac_mode_t            mode_q;
  logic                  irq_q;

  // mode
  mmac_mode_t mode_w;
  assign mode_w = mmac_mode_of(ib_q, psh_q[PSH_SYS]);

  // translation
  logic              hit_w;
  logic [SEG_IW-1:0] idx_w;
  mmac_seg_t         ent_w;
  logic [AW-1:0]     pa_w;
  logic [2:0]        rg_w;
  logic              mem_ok_w;

  mmac_seg_find u_find (
    .tab (tab_q),
    .va  (mem_req.va),
    .hit (hit_w),
    .idx (idx_w)
  );

  assign ent_w    = tab_q[idx_w];
  // privileged modes fall back to identity when no segment matches
  assign pa_w     = hit_w ? AW'(mem_req.va + ent_w.offs) : mem_req.va;
  assign rg_w     = mmac_region(pa_w);
  assign mem_ok_w = mmac_mem_ok(mode_w, mem_req.op, rg_w, hit_w, ent_w.rwx);

  // hardware register rights follow the segment code was last fetched from
  mmac_seg_t cur_w;
  logic      sfr_ok_w;
  assign cur_w    = tab_q[cur_seg_q];
  assign sfr_ok_w = mmac_sfr_ok(mode_w, sfr_req.grp, sfr_req.wr, cur_w.hw_rd, cur_w.hw_wr);

  // apb decode
  logic       acc_w;
  logic       done_w;
  logic [7:0] off_w;
  logic       hi_zero_w;
  logic       mapped_w;
  logic [2:0] agrp_w;
  logic       psh_rd_w;
  logic       apb_ok_w;
  logic       wr_ok_w;
  logic       rd_ok_w;

  assign acc_w     = psel && penable && !pready_q;
  assign done_w    = psel && penable && pready_q;
  assign off_w     = paddr[7:0];
  assign hi_zero_w = paddr[31:8] == 24'h000000;
  assign mapped_w  = hi_zero_w && (off_w == OFF_PSH || off_w == OFF_IB || off_w == OFF_SIDX
                     || off_w == OFF_SATTR || off_w == OFF_SFIRST || off_w == OFF_SLAST
                     || off_w == OFF_SOFFS || off_w == OFF_VSTAT || off_w == OFF_VCLR
                     || off_w == OFF_VEN);
  // internal mode bits sit in the test group so system code cannot raise itself
  assign agrp_w    = (off_w == OFF_IB) ? GRP_TST :
                     (off_w >= OFF_SIDX && off_w <= OFF_SOFFS) ? GRP_SEG : GRP_SYS;
  assign psh_rd_w  = off_w == OFF_PSH && !pwrite && (mode_w == MODE_CTLS || mode_w == MODE_USER);
  assign apb_ok_w  = mapped_w && (mmac_sfr_ok(mode_w, agrp_w, pwrite, 1'b0, 1'b0)
                     || psh_rd_w);
  assign wr_ok_w   = done_w && pwrite && apb_ok_w;
  assign rd_ok_w   = !pwrite && apb_ok_w && off_w != OFF_VCLR;

  logic [31:0] rd_w;
  mmac_seg_t   sel_w;
  assign sel_w = tab_q[sidx_q];
  always_comb begin
    rd_w = 32'h00000000;
    unique case (off_w)
      OFF_PSH:    rd_w = 32'(psh_q);
      OFF_IB:     rd_w = 32'(ib_q);
      OFF_SIDX:   rd_w = 32'(sidx_q);
      OFF_SATTR:  rd_w = 32'({sel_w.hw_wr, sel_w.hw_rd, sel_w.rwx});
      OFF_SFIRST: rd_w = 32'(sel_w.first);
      OFF_SLAST:  rd_w = 32'(sel_w.last);
      OFF_SOFFS:  rd_w = 32'(sel_w.offs);
      OFF_VSTAT:  rd_w = 32'(vstat_q);
      OFF_VEN:    rd_w = 32'(ven_q);
      default:    rd_w = 32'h00000000;
    endcase
  end

  // violations; a new event beats a clear in the same cycle
  logic [VW-1:0] vset_w;
  logic [VW-1:0] vclr_w;
  logic          apb_deny_w;
  assign apb_deny_w = done_w && mapped_w && !apb_ok_w;
  always_comb begin
    vset_w = '0;
    vset_w[V_MRD] = mem_req.req && !mem_ok_w && mem_req.op == OP_RD;
    vset_w[V_MWR] = mem_req.req && !mem_ok_w && mem_req.op == OP_WR;
    vset_w[V_MEX] = mem_req.req && !mem_ok_w && mem_req.op != OP_RD && mem_req.op != OP_WR;
    vset_w[V_SRD] = (sfr_req.req && !sfr_ok_w && !sfr_req.wr) || (apb_deny_w && !pwrite);
    vset_w[V_SWR] = (sfr_req.req && !sfr_ok_w && sfr_req.wr) || (apb_deny_w && pwrite);
  end
  assign vclr_w  = (wr_ok_w && off_w == OFF_VCLR) ? pwdata[VW-1:0] : '0;
  assign vstat_d = (vstat_q & ~vclr_w) | vset_w;

  // apb answer one cycle into the access phase
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= acc_w;
      pslverr_q <= acc_w && !mapped_w;
      prdata_q  <= (acc_w && rd_ok_w) ? rd_w : 32'h00000000;
    end
  end

  // control registers; writes land only on the completing edge
  always_ff @(posedge clk) begin
    if (rst) begin
      psh_q  <= PSH_RST;
      ib_q   <= IB_BOOT;
      sidx_q <= '0;
      ven_q  <= '0;
    end else begin
      if (wr_ok_w && off_w == OFF_PSH) psh_q <= pwdata[PSW-1:0];
      if (trap_entry) psh_q[PSH_SYS] <= 1'b1;
      if (wr_ok_w && off_w == OFF_IB) ib_q <= pwdata[1:0];
      if (wr_ok_w && off_w == OFF_SIDX) sidx_q <= pwdata[SEG_IW-1:0];
      if (wr_ok_w && off_w == OFF_VEN) ven_q <= pwdata[VW-1:0];
    end
  end

  // descriptor table, all entries disabled after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      tab_q <= '0;
    end else if (wr_ok_w) begin
      unique case (off_w)
        OFF_SATTR:  {tab_q[sidx_q].hw_wr, tab_q[sidx_q].hw_rd, tab_q[sidx_q].rwx}
                      <= pwdata[ATTR_W-1:0];
        OFF_SFIRST: tab_q[sidx_q].first <= pwdata[AW-1:0];
        OFF_SLAST:  tab_q[sidx_q].last  <= pwdata[AW-1:0];
        OFF_SOFFS:  tab_q[sidx_q].offs  <= pwdata[AW-1:0];
        default:    tab_q <= tab_q;
      endcase
    end
  end

  // cpu answers, one cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_rsp_q   <= '0;
      sfr_grant_q <= 1'b0;
      sfr_deny_q  <= 1'b0;
      cur_seg_q   <= '0;
      vstat_q     <= '0;
      mode_q      <= MODE_BOOT;
      irq_q       <= 1'b0;
    end else begin
      mem_rsp_q.grant <= mem_req.req && mem_ok_w;
      mem_rsp_q.deny  <= mem_req.req && !mem_ok_w;
      mem_rsp_q.pa    <= (mem_req.req && mem_ok_w) ? pa_w : '0;
      sfr_grant_q     <= sfr_req.req && sfr_ok_w;
      sfr_deny_q      <= sfr_req.req && !sfr_ok_w;
      if (mem_req.req && mem_ok_w && hit_w && mem_req.op == OP_EX) cur_seg_q <= idx_w;
      vstat_q         <= vstat_d;
      mode_q          <= mode_w;
      irq_q           <= |(vstat_q & ven_q);
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign mem_rsp   = mem_rsp_q;
  assign sfr_grant = sfr_grant_q;
  assign sfr_deny  = sfr_deny_q;
  assign cpu_mode  = mode_q;
  assign irq       = irq_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_mode_boot;
    ib_q == IB_BOOT |=> cpu_mode == MODE_BOOT;
  endproperty
  a_mode_boot: assert property (p_mode_boot) else $error("boot bits not seen as boot mode");

  property p_user_miss;
    mem_req.req && mode_w == MODE_USER && !hit_w |=> mem_rsp.deny && !mem_rsp.grant;
  endproperty
  a_user_miss: assert property (p_user_miss) else $error("user access without segment not denied");

  property p_answer;
    mem_req.req |=> mem_rsp.grant != mem_rsp.deny;
  endproperty
  a_answer: assert property (p_answer) else $error("memory request not answered exactly once");

  property p_reloc;
    mem_req.req && mode_w == MODE_USER ##1 mem_rsp.grant
      |-> mem_rsp.pa == AW'($past(mem_req.va) + $past(ent_w.offs));
  endproperty
  a_reloc: assert property (p_reloc) else $error("physical address not va plus offset");

  property p_disabled;
    mem_req.req && mode_w == MODE_USER && ent_w.rwx == 3'h0 |=> !mem_rsp.grant;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled segment matched");

  property p_rom_wr;
    mem_req.req && mem_req.op == OP_WR && (rg_w == RG_TROM || rg_w == RG_AROM) |=> mem_rsp.deny;
  endproperty
  a_rom_wr: assert property (p_rom_wr) else $error("write into rom granted");

  property p_hw_user;
    sfr_req.req && mode_w == MODE_USER && sfr_req.grp == GRP_HW && !sfr_req.wr && !cur_w.hw_rd
      |=> sfr_deny && !sfr_grant;
  endproperty
  a_hw_user: assert property (p_hw_user) else $error("user hw read without right granted");

  property p_deny_zero;
    acc_w && !pwrite && !apb_ok_w ##1 pready |-> prdata == 32'h00000000;
  endproperty
  a_deny_zero: assert property (p_deny_zero) else $error("denied read returned data");

  property p_seg_sys;
    done_w && pwrite && agrp_w == GRP_SEG && mode_w != MODE_SYS
      |=> $stable(tab_q) && $stable(sidx_q);
  endproperty
  a_seg_sys: assert property (p_seg_sys) else $error("segment setup changed outside system mode");

  property p_viol;
    mem_req.req && !mem_ok_w && mem_req.op == OP_WR |=> vstat_q[V_MWR];
  endproperty
  a_viol: assert property (p_viol) else $error("write violation not flagged");

  c_user_grant: cover property (mode_w == MODE_USER && mem_req.req ##1 mem_rsp.grant);
  c_irq:        cover property (mem_rsp.deny ##[1:3] irq);
  c_apb_deny:   cover property (apb_deny_w);
endmodule

/* mmac_pkg.sv */
/*
  mmac package and segment lookup: constants, types and decision functions
  of the mode based memory access control block, plus the combinational
  segment matcher. assumes a single 100 MHz clock domain shared with the cpu.
*/
`timescale 1ns/1ns
package mmac_pkg;
  // table geometry and address width
  localparam int SEG_N  = 64;
  localparam int SEG_IW = 6;
  localparam int AW     = 16;
  localparam int VW     = 5;
  localparam int PSW    = 8;

  // cpu modes, one-hot
  typedef enum logic [4:0] {
    MODE_BOOT = 5'h01,
    MODE_TEST = 5'h02,
    MODE_CTLS = 5'h04,
    MODE_SYS  = 5'h08,
    MODE_USER = 5'h10
  } mmac_mode_t;

  // internal mode bits
  localparam logic [1:0] IB_NONE  = 2'h0;
  localparam logic [1:0] IB_BOOT  = 2'h1;
  localparam logic [1:0] IB_TEST  = 2'h2;
  localparam logic [1:0] IB_CTLS  = 2'h3;
  localparam int         PSH_SYS  = 0;
  localparam logic [PSW-1:0] PSH_RST = 8'h00;

  // memory and register operations
  localparam logic [1:0] OP_RD = 2'h0;
  localparam logic [1:0] OP_WR = 2'h1;
  localparam logic [1:0] OP_EX = 2'h2;

  // register groups
  localparam logic [2:0] GRP_SEG = 3'h0;
  localparam logic [2:0] GRP_SYS = 3'h1;
  localparam logic [2:0] GRP_TST = 3'h2;
  localparam logic [2:0] GRP_HW  = 3'h3;
  localparam logic [2:0] GRP_CPU = 3'h4;

  // fixed physical partition
  localparam logic [AW-1:0] AROM_BASE = 16'h1000;
  localparam logic [AW-1:0] EE_BASE   = 16'h8000;
  localparam logic [AW-1:0] AEE_BASE  = 16'h9000;
  localparam logic [AW-1:0] RAM_BASE  = 16'hC000;
  localparam logic [2:0] RG_TROM = 3'h0;
  localparam logic [2:0] RG_AROM = 3'h1;
  localparam logic [2:0] RG_CEE  = 3'h2;
  localparam logic [2:0] RG_AEE  = 3'h3;
  localparam logic [2:0] RG_RAM  = 3'h4;

  // register offsets
  localparam logic [7:0] OFF_PSH    = 8'h00;
  localparam logic [7:0] OFF_IB     = 8'h04;
  localparam logic [7:0] OFF_SIDX   = 8'h08;
  localparam logic [7:0] OFF_SATTR  = 8'h0C;
  localparam logic [7:0] OFF_SFIRST = 8'h10;
  localparam logic [7:0] OFF_SLAST  = 8'h14;
  localparam logic [7:0] OFF_SOFFS  = 8'h18;
  localparam logic [7:0] OFF_VSTAT  = 8'h1C;
  localparam logic [7:0] OFF_VCLR   = 8'h20;
  localparam logic [7:0] OFF_VEN    = 8'h24;

  // violation bits
  localparam int V_MRD = 0;
  localparam int V_MWR = 1;
  localparam int V_MEX = 2;
  localparam int V_SRD = 3;
  localparam int V_SWR = 4;

  // segment descriptor: attr = {hw_wr, hw_rd, x, w, r}
  typedef struct packed {
    logic            hw_wr;
    logic            hw_rd;
    logic [2:0]      rwx;
    logic [AW-1:0]   first;
    logic [AW-1:0]   last;
    logic [AW-1:0]   offs;
  } mmac_seg_t;
  localparam int ATTR_W = 5;

  typedef struct packed {
    logic            req;
    logic [1:0]      op;
    logic [AW-1:0]   va;
  } mmac_mreq_t;

  typedef struct packed {
    logic            grant;
    logic            deny;
    logic [AW-1:0]   pa;
  } mmac_mrsp_t;

  typedef struct packed {
    logic            req;
    logic            wr;
    logic [2:0]      grp;
  } mmac_sreq_t;

  function automatic mmac_mode_t mmac_mode_of(input logic [1:0] ib, input logic sys);
    case (ib)
      IB_BOOT: mmac_mode_of = MODE_BOOT;
      IB_TEST: mmac_mode_of = MODE_TEST;
      IB_CTLS: mmac_mode_of = MODE_CTLS;
      default: mmac_mode_of = sys ? MODE_SYS : MODE_USER;
    endcase
  endfunction

  function automatic logic [2:0] mmac_region(input logic [AW-1:0] pa);
    if (pa < AROM_BASE)     mmac_region = RG_TROM;
    else if (pa < EE_BASE)  mmac_region = RG_AROM;
    else if (pa < AEE_BASE) mmac_region = RG_CEE;
    else if (pa < RAM_BASE) mmac_region = RG_AEE;
    else                    mmac_region = RG_RAM;
  endfunction

  function automatic logic mmac_mem_ok(input mmac_mode_t m, input logic [1:0] op,
                                       input logic [2:0] rg, input logic hit,
                                       input logic [2:0] rwx);
    logic rom;
    logic app;
    logic ctl;
    rom = (rg == RG_TROM) || (rg == RG_AROM);
    app = (rg == RG_AROM) || (rg == RG_AEE) || (rg == RG_RAM);
    ctl = (rg == RG_TROM) || (rg == RG_CEE) || (rg == RG_RAM);
    mmac_mem_ok = 1'b0;
    if (op <= OP_EX && !(op == OP_WR && rom) && !(op == OP_EX && rg == RG_RAM)) begin
      case (m)
        MODE_BOOT, MODE_CTLS: mmac_mem_ok = ctl;
        MODE_TEST:            mmac_mem_ok = 1'b1;
        MODE_SYS:             mmac_mem_ok = app;
        MODE_USER:            mmac_mem_ok = app && hit && rwx[op];
        default:              mmac_mem_ok = 1'b0;
      endcase
    end
  endfunction

  function automatic logic mmac_sfr_ok(input mmac_mode_t m, input logic [2:0] grp,
                                       input logic wr, input logic hr, input logic hw);
    mmac_sfr_ok = 1'b0;
    if (grp == GRP_CPU) begin
      mmac_sfr_ok = 1'b1;
    end else begin
      case (m)
        // segmentation setup stays with system code only
        MODE_BOOT, MODE_TEST: mmac_sfr_ok = grp < GRP_CPU && grp != GRP_SEG;
        MODE_CTLS:            mmac_sfr_ok = grp == GRP_HW;
        MODE_SYS:             mmac_sfr_ok = grp == GRP_SEG || grp == GRP_SYS || grp == GRP_HW;
        MODE_USER:            mmac_sfr_ok = grp == GRP_HW && (wr ? hw : hr);
        default:              mmac_sfr_ok = 1'b0;
      endcase
    end
  endfunction
endpackage

module mmac_seg_find
  import mmac_pkg::*;
(
  // descriptor table and probe address
  input  wire mmac_seg_t [SEG_N-1:0] tab,
  input  wire logic [AW-1:0]         va,
  // lowest matching enabled segment
  output logic                       hit,
  output logic [SEG_IW-1:0]          idx
);
  // downward loop so the lowest index wins on overlap
  always_comb begin
    hit = 1'b0;
    idx = '0;
    for (int i = SEG_N - 1; i >= 0; i--) begin
      if (tab[i].rwx != 3'h0 && va >= tab[i].first && va <= tab[i].last) begin
        hit = 1'b1;
        idx = SEG_IW'(i);
      end
    end
  end
endmodule

/* mmac_cpu_model.sv */
/*
  cpu core model: issues memory and register requests and trap entries
  toward the access control block, one request per call.
  assumes callers enter its tasks just after a rising clk edge.
*/
`timescale 1ns/1ns
module mmac_cpu_model
  import mmac_pkg::*;
(
  // clock
  input  wire logic clk,
  // requests toward the block
  output mmac_mreq_t mem_req,
  output mmac_sreq_t sfr_req,
  output logic       trap_entry
);
  initial begin
    mem_req = '0;
    sfr_req = '0;
    trap_entry = 1'b0;
  end

  // idle fields are inverted so nothing can lean on stale values
  task automatic mem(input logic [1:0] op, input logic [AW-1:0] va);
    mem_req <= '{req: 1'b1, op: op, va: va};
    @(posedge clk);
    mem_req <= '{req: 1'b0, op: ~op, va: ~va};
    // one idle edge so a following call never rewrites req in this step
    @(posedge clk);
  endtask

  task automatic sfr(input logic wr, input logic [2:0] grp);
    sfr_req <= '{req: 1'b1, wr: wr, grp: grp};
    @(posedge clk);
    sfr_req <= '{req: 1'b0, wr: ~wr, grp: ~grp};
    @(posedge clk);
  endtask

  task automatic trap();
    trap_entry <= 1'b1;
    @(posedge clk);
    trap_entry <= 1'b0;
  endtask
endmodule

/* mmac_top_bench.sv */
/*
  self-checking bench of mmac_top: apb master, cpu model, result queues.
  assumes one 100 MHz clock and the designer's one-cycle answer timing.
*/
`timescale 1ns/1ns
module mmac_top_bench
  import mmac_pkg::*;
;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  mmac_mreq_t  mem_req;
  mmac_mrsp_t  mem_rsp;
  mmac_sreq_t  sfr_req;
  logic        sfr_grant;
  logic        sfr_deny;
  logic        trap_entry;
  mmac_mode_t  cpu_mode;
  logic        irq;
  logic [32:0] q_apb[$];
  logic [17:0] q_mem[$];
  logic [1:0]  q_sfr[$];
  logic [15:0] va;
  int          fail_count = 0;
  int          compares = 0;

  mmac_top i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_rsp(mem_rsp), .sfr_req(sfr_req), .sfr_grant(sfr_grant),
    .sfr_deny(sfr_deny), .trap_entry(trap_entry), .cpu_mode(cpu_mode), .irq(irq));
  mmac_cpu_model i_cpu (.clk(clk), .mem_req(mem_req), .sfr_req(sfr_req),
    .trap_entry(trap_entry));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tally(input logic ok, input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (!ok) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_apb(input logic [32:0] g, input logic [32:0] e);
    tally(g === e, 64'(g), 64'(e));
  endtask
  task automatic cmp_mem(input logic [17:0] g, input logic [17:0] e);
    tally(g === e, 64'(g), 64'(e));
  endtask
  task automatic cmp_sfr(input logic [1:0] g, input logic [1:0] e);
    tally(g === e, 64'(g), 64'(e));
  endtask
  task automatic cmp_state(input logic [31:0] g, input logic [31:0] e);
    tally(g === e, 64'(g), 64'(e));
  endtask

  // answers stand one cycle, so each is taken at the edge that ends it
  always @(posedge clk) begin
    if (pready === 1'b1)
      cmp_apb({pslverr, prdata}, q_apb.size() ? q_apb.pop_front() : 33'h1FFFFFFFF);
    if (mem_rsp.grant === 1'b1 || mem_rsp.deny === 1'b1)
      cmp_mem(mem_rsp, q_mem.size() ? q_mem.pop_front() : 18'h3FFFF);
    if (sfr_grant === 1'b1 || sfr_deny === 1'b1)
      cmp_sfr({sfr_grant, sfr_deny}, q_sfr.size() ? q_sfr.pop_front() : 2'h3);
  end

  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // request held until pready is seen high; no fixed wait assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    q_apb.push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic m(input logic [1:0] op, input logic [15:0] v, input logic g,
                   input logic [15:0] pa);
    q_mem.push_back({g, ~g, pa});
    i_cpu.mem(op, v);
  endtask
  task automatic s(input logic w, input logic [2:0] grp, input logic g);
    q_sfr.push_back({g, ~g});
    i_cpu.sfr(w, grp);
  endtask
  task automatic look();
    repeat (2) @(posedge clk);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    look();
  endtask
  task automatic seg(input logic [5:0] i, input logic [15:0] f, input logic [15:0] l,
                     input logic [15:0] o, input logic [4:0] at);
    apb(1'b1, OFF_SIDX, 32'(i), 33'h0);
    apb(1'b1, OFF_SFIRST, 32'(f), 33'h0);
    apb(1'b1, OFF_SLAST, 32'(l), 33'h0);
    apb(1'b1, OFF_SOFFS, 32'(o), 33'h0);
    apb(1'b1, OFF_SATTR, 32'(at), 33'h0);
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    void'($urandom(98617));
    do_reset();
    cmp_state(cpu_mode, MODE_BOOT);
    s(1'b1, GRP_SEG, 1'b0);
    m(OP_RD, 16'h0000, 1'b1, 16'h0000);
    m(OP_WR, 16'h1000, 1'b0, 16'h0000);
    apb(1'b1, OFF_IB, 32'h2, 33'h0);
    look();
    cmp_state(cpu_mode, MODE_TEST);
    m(OP_WR, 16'h9000, 1'b1, 16'h9000);
    apb(1'b1, OFF_IB, 32'h3, 33'h0);
    look();
    cmp_state(cpu_mode, MODE_CTLS);
    s(1'b0, GRP_SYS, 1'b0);
    s(1'b0, GRP_HW, 1'b1);
    m(OP_RD, 16'h8000, 1'b1, 16'h8000);
    m(OP_RD, 16'h9000, 1'b0, 16'h0000);
    look();
    $display("test privileged modes done");
    // second reset in mid-run must bring back boot mode
    do_reset();
    cmp_state(cpu_mode, MODE_BOOT);
    apb(1'b1, OFF_PSH, 32'h1, 33'h0);
    apb(1'b1, OFF_IB, 32'h0, 33'h0);
    look();
    cmp_state(cpu_mode, MODE_SYS);
    seg(6'h00, 16'h1000, 16'h10FF, 16'h0100, 5'h0D);
    seg(6'h01, 16'h2000, 16'h20FF, 16'h0000, 5'h18);
    m(OP_RD, 16'h9000, 1'b1, 16'h9000);
    m(OP_RD, 16'h0000, 1'b0, 16'h0000);
    m(OP_EX, 16'hC000, 1'b0, 16'h0000);
    s(1'b0, GRP_SEG, 1'b1);
    s(1'b1, GRP_TST, 1'b0);
    apb(1'b1, OFF_PSH, 32'h0, 33'h0);
    look();
    cmp_state(cpu_mode, MODE_USER);
    repeat (4) begin
      va = 16'h1000 | 16'($urandom & 32'hFF);
      m(OP_RD, va, 1'b1, va + 16'h0100);
    end
    m(OP_RD, 16'h10FF, 1'b1, 16'h11FF);
    m(OP_RD, 16'h1100, 1'b0, 16'h0000);
    m(OP_WR, 16'h1010, 1'b0, 16'h0000);
    m(OP_RD, 16'h2000, 1'b0, 16'h0000);
    m(OP_EX, 16'h1010, 1'b1, 16'h1110);
    s(1'b0, GRP_HW, 1'b1);
    s(1'b1, GRP_HW, 1'b0);
    s(1'b1, GRP_CPU, 1'b1);
    s(1'b0, GRP_SEG, 1'b0);
    apb(1'b0, OFF_SFIRST, 32'h0, 33'h0);
    apb(1'b1, OFF_SFIRST, 32'h3000, 33'h0);
    apb(1'b0, OFF_PSH, 32'h0, 33'h0);
    $display("test user mode done");
    i_cpu.trap();
    look();
    cmp_state(cpu_mode, MODE_SYS);
    apb(1'b0, OFF_SFIRST, 32'h0, {1'b0, 32'h2000});
    apb(1'b0, OFF_VSTAT, 32'h0, {1'b0, 32'h1F});
    cmp_state(32'(irq), 32'h0);
    apb(1'b1, OFF_VEN, 32'h04, 33'h0);
    look();
    cmp_state(32'(irq), 32'h1);
    apb(1'b1, OFF_VCLR, 32'h1F, 33'h0);
    look();
    cmp_state(32'(irq), 32'h0);
    apb(1'b0, OFF_VSTAT, 32'h0, 33'h0);
    apb(1'b0, OFF_VCLR, 32'h0, 33'h0);
    // unmapped word: error response, no data
    apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
    look();
    cmp_state(32'(q_apb.size() + q_mem.size() + q_sfr.size()), 32'h0);
    $display("test violations done");
    print_verdict();
  end

  // whole run is under two hundred cycles; this bound leaves wide margin
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end
endmodule
